// >>> include/spa_pkg.sv
// Purpose: Constants for the shared RAM port arbiter
// Assumes: Single clock, byte-wide RAM words
// Notes: Base window compare uses the upper core address bits
package spa_pkg;
  localparam int RAM_BYTES = 1152;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int CORE_ADDR_W = 24;
  localparam int BASE_W = CORE_ADDR_W - 12;
  localparam int WIN_LSB = 12;
  localparam int NUM_SERIAL = 3;
  localparam int NUM_DMA = 6;
  localparam logic [ADDR_W-1:0] RAM_LAST = 11'h47F;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [BASE_W-1:0] BASE_RST = 12'h000;
  localparam logic [NUM_DMA-1:0] DMA_NONE = 6'h00;
  typedef enum logic [1:0] {
    SPA_IDLE = 2'b00,
    SPA_CORE = 2'b01,
    SPA_RISC = 2'b11
  } spa_slot_e;
endpackage : spa_pkg

// >>> logic/spa_arbiter.sv
// Purpose: Shared RAM arbiter between processor core and comm_engine
// Assumes: Core and comm_engine logic on clk; base value supplied by system
// Notes: Core wins a clash; a refused comm_engine request is not stored, the engine must hold it to a free slot
// Notes on behaviour
// - comm_engine may access RAM every cycle the core leaves free
// - Core access completes with no wait
// - Core accesses interleave without corrupting data
// - Each core access costs one engine slot
// - Engine reaches internal buffers in one cycle
// - Six DMA channels, rx and tx for each of three serial channels
// - External buffers moved by DMA, bypassing RAM
// - RAM holds parameters, counters, descriptors, buffers
// - Base register positions the RAM window
// - RAM capacity is 1152 bytes
`timescale 1ns/1ps
module spa_arbiter
  import spa_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Window base
  input wire logic [BASE_W-1:0] base_addr,
  // Core port
  input wire logic core_req,
  input wire logic core_we,
  input wire logic [CORE_ADDR_W-1:0] core_addr,
  input wire logic [DATA_W-1:0] core_wdata,
  output logic core_sel,
  output logic core_ack,
  output logic [DATA_W-1:0] core_rdata,
  // comm_engine port
  input wire logic eng_req,
  input wire logic eng_we,
  input wire logic [ADDR_W-1:0] eng_addr,
  input wire logic [DATA_W-1:0] eng_wdata,
  output logic eng_ready,
  output logic eng_ack,
  output logic [DATA_W-1:0] eng_rdata,
  // Serial DMA requests from engine
  input wire logic [NUM_DMA-1:0] dma_start,
  output logic [NUM_DMA-1:0] dma_busy
);
  // RAM array and registered answers
  logic [DATA_W-1:0] mem_reg [RAM_BYTES];
  logic [DATA_W-1:0] core_rdata_reg;
  logic [DATA_W-1:0] eng_rdata_reg;
  logic [NUM_DMA-1:0] dma_busy_reg;
  spa_slot_e slot_reg;
  spa_slot_e slot_next;

  // Decode, arbitration and port nets
  wire logic [ADDR_W-1:0] core_off = core_addr[ADDR_W-1:0];
  wire logic core_base_hit;
  wire logic core_gap_clear;
  wire logic core_in_range;
  wire logic core_in_win;
  wire logic core_go;
  wire logic core_rd_go;
  wire logic eng_go;
  wire logic eng_in_range;
  wire logic eng_rd_go;
  wire logic [ADDR_W-1:0] port_addr;
  wire logic port_we;
  wire logic [DATA_W-1:0] port_wdata;
  wire logic port_wr_go;

  assign core_base_hit = (core_addr[CORE_ADDR_W-1:WIN_LSB] == base_addr);
  // Bits between offset and base clear, else the window aliases
  assign core_gap_clear = (core_addr[WIN_LSB-1:ADDR_W] == '0);
  assign core_in_range = (core_off <= RAM_LAST);
  assign core_in_win = core_base_hit && core_gap_clear && core_in_range;
  assign core_sel = core_req && core_in_win;

  property p_win;
    @(posedge clk) disable iff (reset)
      core_sel |-> core_addr[CORE_ADDR_W-1:WIN_LSB] == base_addr;
  endproperty
  a_win: assert property (p_win) else $error("window miss");

  property p_gap;
    @(posedge clk) disable iff (reset)
      core_sel |-> core_addr[WIN_LSB-1:ADDR_W] == '0;
  endproperty
  a_gap: assert property (p_gap) else $error("window alias");

  property p_range;
    @(posedge clk) disable iff (reset)
      core_sel |-> core_off <= RAM_LAST;
  endproperty
  a_range: assert property (p_range) else $error("offset past end");

  assign core_go = core_sel;
  assign eng_go = eng_req && !core_go;
  assign eng_ready = !core_go;
  // Next slot owner, core first
  assign slot_next = core_go ? SPA_CORE : (eng_go ? SPA_RISC : SPA_IDLE);

  property p_clash;
    @(posedge clk) disable iff (reset) (core_sel && eng_req) |=> !eng_ack && core_ack;
  endproperty
  a_clash: assert property (p_clash) else $error("clash not resolved");

  property p_slot;
    @(posedge clk) disable iff (reset)
      (core_sel && eng_req) ##1 (eng_req && !core_sel) |=> eng_ack;
  endproperty
  a_slot: assert property (p_slot) else $error("engine slot lost");

  // Single RAM port mux
  assign port_addr = core_go ? core_off : eng_addr;
  assign port_we = core_go ? core_we : eng_we;
  assign port_wdata = core_go ? core_wdata : eng_wdata;
  // one write per cycle, in range
  assign port_wr_go = (core_go || eng_go) && port_we && (port_addr <= RAM_LAST);
  // Read strobes per side
  assign core_rd_go = core_go && !core_we;
  assign eng_in_range = (eng_addr <= RAM_LAST);
  assign eng_rd_go = eng_go && !eng_we && eng_in_range;

  always_ff @(posedge clk) begin
    if (port_wr_go) begin
      mem_reg[port_addr] <= port_wdata;
    end
  end

  property p_wr;
    @(posedge clk) disable iff (reset)
      port_wr_go |=> mem_reg[$past(port_addr)] == $past(port_wdata);
  endproperty
  a_wr: assert property (p_wr) else $error("write lost");

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slot_reg <= SPA_IDLE;
    end else begin
      slot_reg <= slot_next;
    end
  end

  // Acks decoded from the slot owner
  assign core_ack = (slot_reg == SPA_CORE);
  assign eng_ack = (slot_reg == SPA_RISC);

  property p_core_nowait;
    @(posedge clk) disable iff (reset) core_sel |=> core_ack;
  endproperty
  a_core_nowait: assert property (p_core_nowait) else $error("core ack late");

  property p_core_src;
    @(posedge clk) disable iff (reset) core_ack |-> $past(core_sel);
  endproperty
  a_core_src: assert property (p_core_src) else $error("core ack unasked");

  property p_eng_one;
    @(posedge clk) disable iff (reset) (eng_req && !core_sel) |=> eng_ack;
  endproperty
  a_eng_one: assert property (p_eng_one) else $error("engine ack late");

  // engine ack only in a free slot
  property p_eng_src;
    @(posedge clk) disable iff (reset) eng_ack |-> $past(eng_req && !core_sel);
  endproperty
  a_eng_src: assert property (p_eng_src) else $error("engine ack unasked");

  property p_excl;
    @(posedge clk) disable iff (reset) !(core_ack && eng_ack);
  endproperty
  a_excl: assert property (p_excl) else $error("two grants");

  property p_idle;
    @(posedge clk) disable iff (reset)
      (!core_sel && !eng_req) |=> !core_ack && !eng_ack;
  endproperty
  a_idle: assert property (p_idle) else $error("phantom grant");

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_rdata_reg <= DATA_RST;
    end else if (core_rd_go) begin
      core_rdata_reg <= mem_reg[core_off];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      eng_rdata_reg <= DATA_RST;
    end else if (eng_rd_go) begin
      eng_rdata_reg <= mem_reg[eng_addr];
    end
  end

  // core read sees the stored byte
  property p_core_rd;
    @(posedge clk) disable iff (reset)
      core_rd_go |=> core_rdata == mem_reg[$past(core_off)];
  endproperty
  a_core_rd: assert property (p_core_rd) else $error("core read wrong");

  property p_rd;
    @(posedge clk) disable iff (reset)
      eng_rd_go |=> eng_rdata == mem_reg[$past(eng_addr)];
  endproperty
  a_rd: assert property (p_rd) else $error("engine read wrong");

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dma_busy_reg <= DMA_NONE;
    end else begin
      dma_busy_reg <= dma_start;
    end
  end

  property p_dma;
    @(posedge clk) disable iff (reset) 1'b1 |=> dma_busy == $past(dma_start);
  endproperty
  a_dma: assert property (p_dma) else $error("dma flag wrong");

  // Registered data outputs
  assign core_rdata = core_rdata_reg;
  assign eng_rdata = eng_rdata_reg;
  assign dma_busy = dma_busy_reg;
endmodule : spa_arbiter

// >>> testbench/spa_eng_model.sv
// Purpose: comm_engine model issuing reads every cycle
// Assumes: en and clr driven off the falling edge
// Notes: Counts answered engine slots
`timescale 1ns/1ps
module spa_eng_model
  import spa_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic en,
  input wire logic clr,
  // Engine port
  output logic eng_req,
  output logic eng_we,
  output logic [ADDR_W-1:0] eng_addr,
  output logic [DATA_W-1:0] eng_wdata,
  input wire logic eng_ack,
  output logic [7:0] cnt
);
  // read every cycle, held while refused
  assign eng_req = en;
  assign eng_we = 1'b0;
  assign eng_addr = 11'h100;
  assign eng_wdata = 8'h00;
  // Answered slot counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) cnt <= 8'h00;
    else if (clr) cnt <= 8'h00;
    else if (eng_ack) cnt <= cnt + 8'h01;
  end
endmodule : spa_eng_model

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the shared RAM arbiter
// Assumes: Inputs change on the falling edge
// Notes: Bounded by a cycle ceiling
`timescale 1ns/1ps
module tb_top;
  import spa_pkg::*;
  logic clk = 0, reset = 1, core_req = 0, core_we = 0, en = 0, clr = 0;
  logic core_sel, core_ack, eng_req, eng_we, eng_ready, eng_ack;
  logic [BASE_W-1:0] base_addr = 12'h0A5;
  logic [CORE_ADDR_W-1:0] core_addr = 24'h000000;
  logic [DATA_W-1:0] core_wdata = 8'h00, core_rdata, eng_wdata, eng_rdata;
  logic [ADDR_W-1:0] eng_addr;
  logic [NUM_DMA-1:0] dma_start = 6'h00, dma_busy;
  logic [7:0] cnt;
  int err_total = 0, n_tests = 0, cyc = 0;
  always #12.5 clk = ~clk;
  spa_arbiter dut (.clk(clk), .reset(reset), .base_addr(base_addr), .core_req(core_req),
    .core_we(core_we), .core_addr(core_addr), .core_wdata(core_wdata), .core_sel(core_sel),
    .core_ack(core_ack), .core_rdata(core_rdata), .eng_req(eng_req), .eng_we(eng_we),
    .eng_addr(eng_addr), .eng_wdata(eng_wdata), .eng_ready(eng_ready), .eng_ack(eng_ack),
    .eng_rdata(eng_rdata), .dma_start(dma_start), .dma_busy(dma_busy));
  spa_eng_model eng (.clk(clk), .reset(reset), .en(en), .clr(clr), .eng_req(eng_req),
    .eng_we(eng_we), .eng_addr(eng_addr), .eng_wdata(eng_wdata), .eng_ack(eng_ack), .cnt(cnt));
  task conclude;
    $display("tests %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task cmp(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task core(input logic w, input logic [23:0] a, input logic [7:0] d, input logic k);
    @(negedge clk);
    core_req = 1;
    core_we = w;
    core_addr = a;
    core_wdata = d;
    #1;
    cmp({7'h00, core_sel}, {7'h00, k});
    cmp({7'h00, eng_ready}, {7'h00, !k});
    @(negedge clk);
    core_req = 0;
    cmp({7'h00, core_ack}, {7'h00, k});
    if (k && !w) cmp(core_rdata, d);
  endtask : core
  task t_ram;
    core(1, {base_addr, 12'h47F}, 8'h5A, 1);
    core(0, {base_addr, 12'h47F}, 8'h5A, 1);
    core(1, {base_addr, 12'h000}, 8'hC3, 1);
    core(0, {base_addr, 12'h000}, 8'hC3, 1);
    $display("t_ram done");
  endtask : t_ram
  task t_map;
    core(0, {base_addr, 12'h480}, 8'h00, 0);
    core(0, {~base_addr, 12'h000}, 8'h00, 0);
    core(1, {base_addr, 12'hC7F}, 8'hFF, 0);
    core(0, {base_addr, 12'h47F}, 8'h5A, 1);
    $display("t_map done");
  endtask : t_map
  task t_slot;
    core(1, {base_addr, 12'h100}, 8'hE7, 1);
    @(negedge clk);
    clr = 1;
    @(negedge clk);
    clr = 0;
    en = 1;
    core(1, {base_addr, 12'h010}, 8'h96, 1);
    core(0, {base_addr, 12'h010}, 8'h96, 1);
    core(1, {base_addr, 12'h011}, 8'h69, 1);
    core(0, {base_addr, 12'h011}, 8'h69, 1);
    @(negedge clk);
    en = 0;
    repeat (2) @(negedge clk);
    cmp(cnt, 8'h05);
    cmp(eng_rdata, 8'hE7);
    $display("t_slot done");
  endtask : t_slot
  task t_dma;
    @(negedge clk);
    dma_start = 6'h2A;
    @(negedge clk);
    cmp({2'b00, dma_busy}, 8'h2A);
    dma_start = 6'h15;
    @(negedge clk);
    cmp({2'b00, dma_busy}, 8'h15);
    dma_start = 6'h3F;
    @(negedge clk);
    cmp({2'b00, dma_busy}, 8'h3F);
    reset = 1;
    #1;
    cmp({2'b00, dma_busy}, 8'h00);
    cmp(core_rdata, 8'h00);
    cmp(eng_rdata, 8'h00);
    dma_start = 6'h00;
    repeat (2) @(negedge clk);
    reset = 0;
    core(0, {base_addr, 12'h47F}, 8'h5A, 1);
    $display("t_dma done");
  endtask : t_dma
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk) reset = 0;
    t_ram();
    t_map();
    t_slot();
    t_dma();
    conclude();
  end
endmodule : tb_top
